/* verilog/imr_master.sv */
`timescale 1ns/1ps
// Notes on behaviour
// - receive request ignored unless port idle
// - each rollover toggles scl, each fall shifts sda in
// - eighth fall: buffer loaded, flags set, idle
// - buffer read clears buffer full in receive
// - byte while buffer full sets overflow
// - buffer write while busy sets write collision
// - ack sequence: scl low, ack data out
// - ack: period, release, period, low, idle
// - stop: sda low, count, release scl
// - period later release sda, stop, flag
// - reset disables port, drops transfer
// - start/stop seen cleared by reset, disable
// - busy bus stop raises port interrupt
// - expected one sampled zero: collision, idle
// - transmit collision: halt, clear full, release
// - condition collision: abort, release, clear enables
// - after collision stop sets interrupt flag
// - write after collision restarts at bit one
// - counter reloads from rate reload register
module imr_master
    import imr_pkg::*;
(
    // clock and reset
    input  wire logic       clk,
    input  wire logic       nrst,
    // register port
    input  wire logic [2:0] addr,
    input  wire logic [7:0] wdata,
    input  wire logic       wr,
    input  wire logic       rd,
    output logic      [7:0] rdata,
    // serial clock pin
    input  wire logic       scl_in,
    output logic            scl_out,
    output logic            scl_oe,
    // serial data pin
    input  wire logic       sda_in,
    output logic            sda_out,
    output logic            sda_oe,
    // interrupt
    output logic            port_irq
);

    ////////////////////////////////////////////////////////////////////
    // declarations
    logic       rst_a_ff, rst_b_ff, rst_n;
    logic [1:0] scl_sy_ff, sda_sy_ff;
    logic       scl_s, sda_s, scl_d_ff, sda_d_ff;
    imr_state_t state_ff;
    logic [1:0] ph_ff;
    logic [3:0] cnt_ff;
    logic [7:0] shift_ff, buf_ff, reload_ff, brg_ff, rdata_ff;
    logic       scl_drv_ff, sda_drv_ff;
    logic       ack_stat_ff;
    logic       start_en_ff, stop_en_ff, rx_en_ff, ack_en_ff;
    logic       ack_data_ff;
    logic       full_ff, start_sn_ff, stop_sn_ff;
    logic       pif_ff, ovf_ff, write_collision_flag_ff, bcol_ff;
    logic       en_ff, ie_ff, irq_ff;
    logic       ev_rx_ff, ev_ack_ff, ev_stop_ff, ev_start_ff;
    logic       ev_tx_ff, ev_col_ff;
    logic       idle, brg_hold, tick;
    logic       wr_ctrl, wr_buf, wr_flag, rd_buf;
    logic       buf_take, start_det, stop_det;

    ////////////////////////////////////////////////////////////////////
    // reset release through two flip-flops
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rst_a_ff <= 1'b0;
            rst_b_ff <= 1'b0;
        end else begin
            rst_a_ff <= 1'b1;
            rst_b_ff <= rst_a_ff;
        end
    end
    assign rst_n = rst_b_ff;

    // pin synchronisers, only stage two is read
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            scl_sy_ff <= 2'h3;
            sda_sy_ff <= 2'h3;
            scl_d_ff  <= 1'b1;
            sda_d_ff  <= 1'b1;
        end else begin
            scl_sy_ff <= {scl_sy_ff[0], scl_in};
            sda_sy_ff <= {sda_sy_ff[0], sda_in};
            scl_d_ff  <= scl_s;
            sda_d_ff  <= sda_s;
        end
    end
    assign scl_s = scl_sy_ff[1];
    assign sda_s = sda_sy_ff[1];

    // bus condition detectors
    assign start_det = scl_s && scl_d_ff && sda_d_ff && !sda_s;
    assign stop_det  = scl_s && scl_d_ff && !sda_d_ff && sda_s;

    ////////////////////////////////////////////////////////////////////
    // register port decode
    assign idle     = (state_ff == ST_IDLE);
    assign wr_ctrl  = wr && (addr == ADR_CTRL);
    assign wr_buf   = wr && (addr == ADR_BUF);
    assign wr_flag  = wr && (addr == ADR_FLAG);
    assign rd_buf   = rd && (addr == ADR_BUF);
    assign buf_take = wr_buf && idle && en_ff;

    // read data, one cycle after the strobe
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_ff <= RST_BYTE;
        end else if (rd) begin
            case (addr)
                ADR_CTRL: begin
                    rdata_ff <= RST_BYTE;
                    rdata_ff[CB_START]   <= start_en_ff;
                    rdata_ff[CB_STOP]    <= stop_en_ff;
                    rdata_ff[CB_RX]      <= rx_en_ff;
                    rdata_ff[CB_ACK]     <= ack_en_ff;
                    rdata_ff[CB_ACKDATA] <= ack_data_ff;
                    rdata_ff[CB_ACK_RECEIVED_STATUS] <= ack_stat_ff;
                end
                ADR_STAT: begin
                    rdata_ff <= RST_BYTE;
                    rdata_ff[SB_FULL]    <= full_ff;
                    rdata_ff[SB_STARTSN] <= start_sn_ff;
                    rdata_ff[SB_STOPSN]  <= stop_sn_ff;
                    rdata_ff[SB_BUSY]    <= !idle;
                end
                ADR_FLAG: begin
                    rdata_ff <= RST_BYTE;
                    rdata_ff[FB_PORT] <= pif_ff;
                    rdata_ff[FB_OVF]  <= ovf_ff;
                    rdata_ff[FB_WRITE_COLLISION_FLAG] <= write_collision_flag_ff;
                    rdata_ff[FB_BCOL] <= bcol_ff;
                end
                ADR_BUF:    rdata_ff <= buf_ff;
                ADR_RELOAD: rdata_ff <= reload_ff;
                ADR_CFG: begin
                    rdata_ff <= RST_BYTE;
                    rdata_ff[GB_EN] <= en_ff;
                    rdata_ff[GB_IE] <= ie_ff;
                end
                default:    rdata_ff <= RST_BYTE;
            endcase
        end else begin
            rdata_ff <= RST_BYTE;
        end
    end
    assign rdata = rdata_ff;

    // configuration and rate reload
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            en_ff     <= 1'b0;
            ie_ff     <= 1'b0;
            reload_ff <= RST_RELOAD;
        end else begin
            if (wr && (addr == ADR_CFG)) begin
                en_ff <= wdata[GB_EN];
                ie_ff <= wdata[GB_IE];
            end
            if (wr && (addr == ADR_RELOAD)) begin
                reload_ff <= wdata;
            end
        end
    end

    // control bits, taken only while idle
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            start_en_ff <= 1'b0;
            stop_en_ff  <= 1'b0;
            rx_en_ff    <= 1'b0;
            ack_en_ff   <= 1'b0;
            ack_data_ff <= 1'b0;
        end else if (!en_ff || ev_col_ff) begin
            start_en_ff <= 1'b0;
            stop_en_ff  <= 1'b0;
            rx_en_ff    <= 1'b0;
            ack_en_ff   <= 1'b0;
        end else begin
            if (ev_start_ff) start_en_ff <= 1'b0;
            if (ev_stop_ff)  stop_en_ff  <= 1'b0;
            if (ev_rx_ff)    rx_en_ff    <= 1'b0;
            if (ev_ack_ff)   ack_en_ff   <= 1'b0;
            if (wr_ctrl && idle) begin
                start_en_ff <= wdata[CB_START];
                stop_en_ff  <= wdata[CB_STOP];
                rx_en_ff    <= wdata[CB_RX];
                ack_en_ff   <= wdata[CB_ACK];
                ack_data_ff <= wdata[CB_ACKDATA];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // baud counter, held while scl is stretched low
    assign brg_hold = (!scl_drv_ff && !scl_s)
                   || ((state_ff == ST_STOP) && (ph_ff == PH_0) && sda_s);
    assign tick = !idle && !brg_hold && (brg_ff == RST_BYTE);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            brg_ff <= RST_RELOAD;
        end else if (idle || brg_hold || tick) begin
            brg_ff <= reload_ff;
        end else begin
            brg_ff <= brg_ff - 8'h01;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // master sequencer
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_ff    <= ST_IDLE;
            ph_ff       <= PH_0;
            cnt_ff      <= 4'h0;
            shift_ff    <= RST_BYTE;
            scl_drv_ff  <= 1'b0;
            sda_drv_ff  <= 1'b0;
            ack_stat_ff <= 1'b0;
            ev_rx_ff    <= 1'b0;
            ev_ack_ff   <= 1'b0;
            ev_stop_ff  <= 1'b0;
            ev_start_ff <= 1'b0;
            ev_tx_ff    <= 1'b0;
            ev_col_ff   <= 1'b0;
        end else begin
            ev_rx_ff    <= 1'b0;
            ev_ack_ff   <= 1'b0;
            ev_stop_ff  <= 1'b0;
            ev_start_ff <= 1'b0;
            ev_tx_ff    <= 1'b0;
            ev_col_ff   <= 1'b0;
            if (!en_ff) begin
                state_ff   <= ST_IDLE;
                scl_drv_ff <= 1'b0;
                sda_drv_ff <= 1'b0;
            end else begin
                case (state_ff)
                    ST_IDLE: begin
                        ph_ff  <= PH_0;
                        cnt_ff <= 4'h0;
                        if (buf_take) begin
                            state_ff <= ST_TX;
                            shift_ff <= wdata;
                            scl_drv_ff <= 1'b1;
                        end else if (ev_rx_ff || ev_ack_ff || ev_stop_ff
                                     || ev_start_ff || ev_col_ff) begin
                            state_ff <= ST_IDLE;
                        end else if (start_en_ff) begin
                            state_ff <= ST_START;
                        end else if (stop_en_ff) begin
                            state_ff   <= ST_STOP;
                            scl_drv_ff <= 1'b1;
                            sda_drv_ff <= 1'b1;
                        end else if (ack_en_ff) begin
                            state_ff   <= ST_ACK;
                            scl_drv_ff <= 1'b1;
                            sda_drv_ff <= !ack_data_ff;
                        end else if (rx_en_ff) begin
                            state_ff   <= ST_RX;
                            scl_drv_ff <= 1'b1;
                            sda_drv_ff <= 1'b0;
                        end
                    end
                    ST_START: begin
                        if (ph_ff == PH_0 && (!scl_s || !sda_s)
                            && !sda_drv_ff) begin
                            state_ff  <= ST_IDLE;
                            ev_col_ff <= 1'b1;
                            sda_drv_ff <= 1'b0;
                        end else if (tick && ph_ff == PH_0) begin
                            sda_drv_ff <= 1'b1;
                            ph_ff      <= PH_1;
                        end else if (tick) begin
                            state_ff    <= ST_IDLE;
                            ev_start_ff <= 1'b1;
                        end
                    end
                    ST_TX: begin
                        if (tick && ph_ff == PH_0) begin
                            scl_drv_ff <= 1'b0;
                            ph_ff      <= PH_1;
                        end else if (tick) begin
                            scl_drv_ff <= 1'b1;
                            ph_ff      <= PH_0;
                            cnt_ff     <= cnt_ff + 4'h1;
                            shift_ff   <= {shift_ff[6:0], 1'b0};
                            if (cnt_ff == LAST_ABIT) begin
                                ack_stat_ff <= sda_s;
                                state_ff    <= ST_IDLE;
                                ev_rx_ff    <= 1'b0;
                                ev_tx_ff    <= 1'b1;
                            end else if (!sda_drv_ff && !sda_s) begin
                                state_ff   <= ST_IDLE;
                                ev_col_ff  <= 1'b1;
                                scl_drv_ff <= 1'b0;
                                sda_drv_ff <= 1'b0;
                            end
                        end else if (ph_ff == PH_0) begin
                            // data changes while scl is low
                            sda_drv_ff <= (cnt_ff == LAST_ABIT) ? 1'b0
                                                                : !shift_ff[7];
                        end
                    end
                    ST_RX: begin
                        if (tick && ph_ff == PH_0) begin
                            scl_drv_ff <= 1'b0;
                            ph_ff      <= PH_1;
                        end else if (tick) begin
                            scl_drv_ff <= 1'b1;
                            ph_ff      <= PH_0;
                            shift_ff   <= {shift_ff[6:0], sda_s};
                            cnt_ff     <= cnt_ff + 4'h1;
                            if (cnt_ff == LAST_DBIT) begin
                                state_ff <= ST_IDLE;
                                ev_rx_ff <= 1'b1;
                            end
                        end
                    end
                    ST_ACK: begin
                        if (tick && ph_ff == PH_0) begin
                            scl_drv_ff <= 1'b0;
                            ph_ff      <= PH_1;
                        end else if (tick) begin
                            scl_drv_ff <= 1'b1;
                            state_ff   <= ST_IDLE;
                            if (!sda_drv_ff && !sda_s) begin
                                ev_col_ff  <= 1'b1;
                                scl_drv_ff <= 1'b0;
                                sda_drv_ff <= 1'b0;
                            end else begin
                                ev_ack_ff <= 1'b1;
                            end
                        end
                    end
                    ST_STOP: begin
                        if (tick && ph_ff == PH_0) begin
                            scl_drv_ff <= 1'b0;
                            ph_ff      <= PH_1;
                        end else if (tick && ph_ff == PH_1) begin
                            sda_drv_ff <= 1'b0;
                            ph_ff      <= PH_2;
                        end else if (tick) begin
                            state_ff <= ST_IDLE;
                            if (!sda_s) begin
                                ev_col_ff <= 1'b1;
                            end else begin
                                ev_stop_ff <= 1'b1;
                            end
                        end else if (ph_ff == PH_1 && !scl_s
                                     && scl_d_ff) begin
                            state_ff   <= ST_IDLE;
                            ev_col_ff  <= 1'b1;
                            sda_drv_ff <= 1'b0;
                        end
                    end
                    default: begin
                        state_ff <= ST_IDLE;
                    end
                endcase
            end
        end
    end

    // open-drain drivers, low or released
    assign scl_out = 1'b0;
    assign sda_out = 1'b0;
    assign scl_oe  = scl_drv_ff;
    assign sda_oe  = sda_drv_ff;

    ////////////////////////////////////////////////////////////////////
    // transfer buffer and buffer full
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            buf_ff  <= RST_BYTE;
            full_ff <= 1'b0;
        end else if (!en_ff) begin
            full_ff <= 1'b0;
        end else if (ev_rx_ff) begin
            buf_ff  <= shift_ff;
            full_ff <= 1'b1;
        end else if (buf_take) begin
            buf_ff  <= wdata;
            full_ff <= 1'b1;
        end else if (ev_col_ff || ev_tx_ff) begin
            full_ff <= 1'b0;
        end else if (rd_buf && (state_ff != ST_TX)) begin
            full_ff <= 1'b0;
        end
    end

    // start and stop seen
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            start_sn_ff <= 1'b0;
            stop_sn_ff  <= 1'b0;
        end else if (!en_ff) begin
            start_sn_ff <= 1'b0;
            stop_sn_ff  <= 1'b0;
        end else if (start_det) begin
            start_sn_ff <= 1'b1;
            stop_sn_ff  <= 1'b0;
        end else if (stop_det) begin
            start_sn_ff <= 1'b0;
            stop_sn_ff  <= 1'b1;
        end
    end

    // event flags, set wins over write-one clear
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pif_ff  <= 1'b0;
            ovf_ff  <= 1'b0;
            write_collision_flag_ff <= 1'b0;
            bcol_ff <= 1'b0;
        end else begin
            if (ev_rx_ff || ev_ack_ff || ev_stop_ff || ev_start_ff
                || ev_tx_ff || (stop_det && (start_sn_ff || bcol_ff))) begin
                pif_ff <= 1'b1;
            end else if (wr_flag && wdata[FB_PORT]) begin
                pif_ff <= 1'b0;
            end
            if (ev_rx_ff && full_ff) begin
                ovf_ff <= 1'b1;
            end else if (wr_flag && wdata[FB_OVF]) begin
                ovf_ff <= 1'b0;
            end
            if (wr_buf && !idle) begin
                write_collision_flag_ff <= 1'b1;
            end else if (wr_flag && wdata[FB_WRITE_COLLISION_FLAG]) begin
                write_collision_flag_ff <= 1'b0;
            end
            if (ev_col_ff) begin
                bcol_ff <= 1'b1;
            end else if (wr_flag && wdata[FB_BCOL]) begin
                bcol_ff <= 1'b0;
            end
        end
    end

    // interrupt output
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_ff <= 1'b0;
        end else begin
            irq_ff <= ie_ff && (pif_ff || bcol_ff);
        end
    end
    assign port_irq = irq_ff;

endmodule

/* verilog/imr_pkg.sv */
package imr_pkg;

    // register indices on the plain register port
    localparam logic [2:0] ADR_CTRL   = 3'h0; // second control register
    localparam logic [2:0] ADR_STAT   = 3'h1; // port status register
    localparam logic [2:0] ADR_FLAG   = 3'h2; // event flags, write 1 clears
    localparam logic [2:0] ADR_BUF    = 3'h3; // transfer buffer
    localparam logic [2:0] ADR_RELOAD = 3'h4; // rate reload register
    localparam logic [2:0] ADR_CFG    = 3'h5; // port enable, irq enable

    // second control register fields
    localparam int CB_START   = 0;
    localparam int CB_STOP    = 2;
    localparam int CB_RX      = 3;
    localparam int CB_ACK     = 4;
    localparam int CB_ACKDATA = 5;
    localparam int CB_ACK_RECEIVED_STATUS = 6;

    // status fields
    localparam int SB_FULL    = 0;
    localparam int SB_STARTSN = 1;
    localparam int SB_STOPSN  = 2;
    localparam int SB_BUSY    = 3;

    // flag fields
    localparam int FB_PORT    = 0;
    localparam int FB_OVF     = 1;
    localparam int FB_WRITE_COLLISION_FLAG    = 2;
    localparam int FB_BCOL    = 3;

    // config fields
    localparam int GB_EN      = 0;
    localparam int GB_IE      = 1;

    // reset values and counts
    localparam logic [7:0] RST_RELOAD = 8'h09;
    localparam logic [7:0] RST_BYTE   = 8'h00;
    localparam logic [3:0] LAST_DBIT  = 4'h7; // eighth bit of a byte
    localparam logic [3:0] LAST_ABIT  = 4'h8; // ninth (acknowledge) bit

    // phases within a sequence
    localparam logic [1:0] PH_0 = 2'h0;
    localparam logic [1:0] PH_1 = 2'h1;
    localparam logic [1:0] PH_2 = 2'h2;

    typedef enum logic [5:0] {
        ST_IDLE  = 6'h01,
        ST_START = 6'h02,
        ST_TX    = 6'h04,
        ST_RX    = 6'h08,
        ST_ACK   = 6'h10,
        ST_STOP  = 6'h20
    } imr_state_t;

endpackage

/* test/imr_master_asserts.sv */
`timescale 1ns/1ps
module imr_master_asserts
    import imr_pkg::*;
(
    // clock, reset and register port
    input wire logic       clk,
    input wire logic       nrst,
    input wire logic [2:0] addr,
    input wire logic [7:0] wdata,
    input wire logic       wr,
    input wire logic       rd,
    input wire logic [7:0] rdata,
    // pins and interrupt
    input wire logic       scl_in,
    input wire logic       scl_out,
    input wire logic       scl_oe,
    input wire logic       sda_in,
    input wire logic       sda_out,
    input wire logic       sda_oe,
    input wire logic       port_irq
);
    logic ie_ff;
    logic cw;
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    assign cw = wr && addr == ADR_CTRL;
    // shadow of the interrupt enable
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ie_ff <= 1'b0;
        end else if (wr && addr == ADR_CFG) begin
            ie_ff <= wdata[GB_IE];
        end
    end
    ////////////////////////////////////////////////////////////////////////
    a_open_drain:
        assert property (!scl_out && !sda_out)
        else $error("pin driven high");
    a_rx_clocks:
        assert property (cw && wdata[CB_RX] && !scl_oe |-> ##[1:4] scl_oe)
        else $error("receive did not pull scl");
    a_ack_drive:
        assert property (cw && wdata[CB_ACK] && !wdata[CB_ACKDATA] && scl_oe
            |-> ##[1:4] sda_oe)
        else $error("acknowledge not driven");
    a_nak_float:
        assert property (cw && wdata[CB_ACK] && wdata[CB_ACKDATA]
            |=> !sda_oe [*4])
        else $error("not-acknowledge drove sda");
    a_stop_sda:
        assert property (cw && wdata[CB_STOP] && scl_oe |-> ##[1:4] sda_oe)
        else $error("stop did not pull sda");
    a_irq_gated:
        assert property (!ie_ff [*2] |-> !port_irq)
        else $error("interrupt while disabled");
    a_disable_rel:
        assert property (wr && addr == ADR_CFG && !wdata[GB_EN]
            |-> ##[1:3] (!scl_oe && !sda_oe))
        else $error("lines held after disable");
    a_scl_hold:
        assert property ($rose(scl_oe) |=> scl_oe [*3])
        else $error("scl low too short");
    a_sda_hold:
        assert property ($rose(sda_oe) |=> sda_oe [*3])
        else $error("sda low phase too short");
    // main scenarios
    cover property (cw && wdata[CB_RX]);
    cover property (cw && wdata[CB_STOP]);
    cover property (rd && addr == ADR_BUF);
endmodule
bind imr_master imr_master_asserts u_imr_master_asserts (
    .clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .scl_in(scl_in), .scl_out(scl_out), .scl_oe(scl_oe),
    .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
    .port_irq(port_irq));

/* test/imr_slave.sv */
`timescale 1ns/1ps
module imr_slave (
    // clock and bus level
    input  wire logic       clk,
    input  wire logic       nrst,
    input  wire logic       scl,
    // open-drain pulls
    output logic            sda_pull,
    output logic            scl_pull,
    // bench control
    input  wire logic       arm,
    input  wire logic [7:0] tx_byte,
    input  wire logic       jam,
    input  wire logic [3:0] stretch
);
    logic [7:0] sh_ff;
    logic [3:0] cnt_ff;
    logic [3:0] hold_ff;
    logic       need_ff;
    logic       scl_d_ff;
    logic       bit_ff;
    // next bit only while scl low, msb first, released after eight
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            {sh_ff, cnt_ff, hold_ff, need_ff, scl_d_ff, bit_ff} <= '0;
        end else if (arm) begin
            sh_ff   <= tx_byte;
            cnt_ff  <= 4'h8;
            need_ff <= 1'b1;
        end else begin
            scl_d_ff <= scl;
            if (scl_d_ff && !scl) begin
                need_ff <= 1'b1;
                hold_ff <= stretch; // slow answer stretches scl
            end else if (hold_ff != 4'h0) begin
                hold_ff <= hold_ff - 4'h1;
            end
            if (need_ff && !scl) begin
                bit_ff  <= cnt_ff != 4'h0 && !sh_ff[7];
                sh_ff   <= {sh_ff[6:0], 1'b0};
                cnt_ff  <= cnt_ff - {3'h0, cnt_ff != 4'h0};
                need_ff <= 1'b0;
            end
        end
    end
    assign sda_pull = bit_ff | jam; // jam forces arbitration loss
    assign scl_pull = hold_ff != 4'h0;
endmodule

/* test/imr_master_tb.sv */
`timescale 1ns/1ps
module imr_master_tb
    import imr_pkg::*;
();
    logic       clk     = 1'b0;
    logic       nrst    = 1'b0;
    logic [2:0] addr    = 3'h0;
    logic [7:0] wdata   = 8'h00;
    logic       wr      = 1'b0;
    logic       rd      = 1'b0;
    logic       arm     = 1'b0;
    logic       jam     = 1'b0;
    logic [7:0] tx_byte = 8'h00;
    logic [3:0] stretch = 4'h0;
    logic [7:0] rdata;
    logic [7:0] d;
    logic       scl_oe, sda_oe, port_irq, scl_pull, sda_pull;
    wire        scl_w = !(scl_oe | scl_pull); // pulled-up bus
    wire        sda_w = !(sda_oe | sda_pull);
    int         n_mismatch = 0;
    int         samples_checked = 0;
    int         cyc = 0;
    imr_master u_imr_master (.clk(clk), .nrst(nrst), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .scl_in(scl_w),
        .scl_out(), .scl_oe(scl_oe), .sda_in(sda_w), .sda_out(),
        .sda_oe(sda_oe), .port_irq(port_irq));
    imr_slave u_imr_slave (.clk(clk), .nrst(nrst), .scl(scl_w),
        .sda_pull(sda_pull), .scl_pull(scl_pull), .arm(arm),
        .tx_byte(tx_byte), .jam(jam), .stretch(stretch));
    ////////////////////////////////////////////////////////////////////////
    function automatic logic [7:0] bm(input int b);
        return 8'h01 << b;
    endfunction
    task automatic wreg(input logic [2:0] a, input logic [7:0] v);
        @(posedge clk);
        addr  <= a;
        wdata <= v;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
    endtask
    task automatic rreg(input logic [2:0] a, output logic [7:0] v);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd   <= 1'b0;
        #1 v = rdata;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic rchk(input logic [2:0] a, input logic [7:0] m,
                        input logic [7:0] exp);
        rreg(a, d);
        chk(d & m, exp);
    endtask
    // bounded flag poll
    task automatic wait_flag(input logic [7:0] m);
        d = 8'h00;
        for (int i = 0; i < 300 && (d & m) == 8'h00; i++) begin
            rreg(ADR_FLAG, d);
        end
        chk(d & m, m);
    endtask
    task automatic rx(input logic [7:0] b);
        @(posedge clk);
        tx_byte <= b;
        arm     <= 1'b1;
        @(posedge clk);
        arm     <= 1'b0;
        wreg(ADR_CTRL, bm(CB_RX));
        repeat (4) @(posedge clk);
    endtask
    task automatic conclude();
        $display("compared %0d mismatched %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    always #50 clk = ~clk;
    // hang guard
    always @(posedge clk) begin
        cyc++;
        if (cyc == 10000) begin
            n_mismatch++;
            conclude();
        end
    end
    initial begin
        repeat (4) @(posedge clk);
        nrst <= 1'b1;
        repeat (3) @(posedge clk);
        rchk(ADR_CFG, 8'hFF, 8'h00);
        rchk(ADR_STAT, 8'h06, 8'h00);
        rchk(ADR_RELOAD, 8'hFF, RST_RELOAD);
        wreg(ADR_RELOAD, 8'h03);
        wreg(ADR_CFG, bm(GB_EN) | bm(GB_IE));
        rx(8'hA5);
        wreg(ADR_BUF, 8'h5A);
        wreg(ADR_CTRL, bm(CB_ACK) | bm(CB_ACKDATA));
        wait_flag(bm(FB_PORT));
        rchk(ADR_FLAG, 8'hFF, bm(FB_PORT) | bm(FB_WRITE_COLLISION_FLAG));
        rchk(ADR_CTRL, bm(CB_RX) | bm(CB_ACK), 8'h00);
        chk({7'h00, port_irq}, 8'h01);
        rchk(ADR_BUF, 8'hFF, 8'hA5);
        rchk(ADR_STAT, bm(SB_FULL), 8'h00);
        wreg(ADR_FLAG, 8'hFF);
        rx(8'h3C);
        wait_flag(bm(FB_PORT));
        wreg(ADR_FLAG, 8'hFF);
        stretch <= 4'h6;
        rx(8'hC3);
        wait_flag(bm(FB_PORT));
        stretch <= 4'h0;
        rchk(ADR_FLAG, bm(FB_OVF), bm(FB_OVF));
        rchk(ADR_BUF, 8'hFF, 8'hC3);
        wreg(ADR_FLAG, 8'hFF);
        wreg(ADR_CTRL, bm(CB_ACK));
        wait_flag(bm(FB_PORT));
        rchk(ADR_CTRL, bm(CB_ACK), 8'h00);
        wreg(ADR_FLAG, 8'hFF);
        wreg(ADR_CTRL, bm(CB_STOP));
        wait_flag(bm(FB_PORT));
        rchk(ADR_STAT, bm(SB_STOPSN), bm(SB_STOPSN));
        rchk(ADR_CTRL, bm(CB_STOP), 8'h00);
        wreg(ADR_FLAG, 8'hFF);
        rx(8'hFF);
        wait_flag(bm(FB_PORT));
        jam <= 1'b1;
        wreg(ADR_CTRL, bm(CB_ACK) | bm(CB_ACKDATA));
        wait_flag(bm(FB_BCOL));
        rchk(ADR_CTRL, bm(CB_ACK), 8'h00);
        chk({6'h00, scl_oe, sda_oe}, 8'h00);
        wreg(ADR_FLAG, 8'h01);
        jam <= 1'b0;
        wait_flag(bm(FB_PORT));
        wreg(ADR_CFG, 8'h00);
        rchk(ADR_STAT, 8'h06, 8'h00);
        conclude();
    end
endmodule
